// >>> scp_pkg.sv
// constants, register map and types of the serial port control block
package scp_pkg;
    // register addresses on the plain register port
    localparam logic [2:0] SCP_MODE_ADDR = 3'h0;
    localparam logic [2:0] SCP_CTRL_ADDR = 3'h1;
    localparam logic [2:0] SCP_STAT_ADDR = 3'h2;
    localparam logic [2:0] SCP_TXD_ADDR = 3'h3;
    localparam logic [2:0] SCP_RXD_ADDR = 3'h4;
    // reset values
    localparam logic [7:0] SCP_CTRL_RST = 8'h00;
    localparam logic [7:0] SCP_MODE_RST = 8'h00;
    localparam logic [7:0] SCP_STAT_RST = 8'h84;
    localparam logic [7:0] SCP_TXD_RST = 8'hff;
    localparam logic [7:0] SCP_RXD_RST = 8'h00;
    // serial_control_reg fields
    localparam int CTL_TX_EMPTY_IE = 7;
    localparam int CTL_RX_IE = 6;
    localparam int CTL_TX_ON = 5;
    localparam int CTL_RX_ON = 4;
    localparam int CTL_ADDR_WAIT = 3;
    localparam int CTL_TX_DONE_IE = 2;
    localparam int CTL_CLK_SRC = 1;
    localparam int CTL_CLK_OUT = 0;
    // serial_mode_reg fields
    localparam int MOD_SYNC = 7;
    localparam int MOD_ADDR_FRAME = 2;
    localparam int MOD_DIV_HI = 1;
    localparam int MOD_DIV_LO = 0;
    // serial_status_reg fields
    localparam int ST_TX_EMPTY = 7;
    localparam int ST_RX_FULL = 6;
    localparam int ST_OVERRUN = 5;
    localparam int ST_FRAMING = 4;
    localparam int ST_PARITY = 3;
    localparam int ST_TX_END = 2;
    localparam int ST_ADDR_BIT = 1;
    localparam int ST_ADDR_BIT_TX = 0;
    // timing: internal clock gives 16 ticks per bit
    localparam int CLK_MHZ = 100;
    localparam int BASE_BAUD = 230400;
    localparam logic [11:0] TICK_DIV = 12'(CLK_MHZ * 1000000 / (BASE_BAUD * 16) - 1);
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [2:0] {
        SCP_IDLE = 3'b000,
        SCP_START = 3'b001,
        SCP_DATA = 3'b010,
        SCP_ADDR = 3'b011,
        SCP_STOP = 3'b100
    } scp_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } scp_bus_t;
endpackage : scp_pkg

// >>> scp_serial_port.sv
// serial port control block: control register, flags, irq gating, clock pin, framer
`timescale 1ns/100ps
// How it works
// RULE_01: control register always read/write; zero on reset, standby, module standby.
// RULE_02: tx-empty irq requested when empty flag set by holding-to-shift move.
// RULE_03: tx-empty irq drops when flag read-then-cleared or its enable cleared.
// RULE_04: rx enable gates rx-full irq on holding load, and rx error irq.
// RULE_05: rx irqs drop when flag read-then-cleared or rx enable cleared.
// RULE_06: tx_on low disables transmitter and holds empty flag at one.
// RULE_07: with tx_on, transmission starts once empty flag clears after data write.
// RULE_08: clearing rx_on stops receiver; receive flags keep their values.
// RULE_09: with rx_on, reception starts on start bit, or clock in sync mode.
// RULE_10: address wait enable counts only in async mode with addressed frames.
// RULE_11: address wait enable cleared by software zero or received address bit one.
// RULE_12: during address wait: no load, no errors, no flags, no rx irqs.
// RULE_13: address character sets status bit, ends wait, enables irqs and flags.
// RULE_14: tx-done irq when holding register empty as last bit goes out.
// RULE_15: tx-done irq drops on empty flag clear with end, or enable clear.
// RULE_16: two clock-select bits choose clock source and serial clock pin direction.
// RULE_17: clock output select counts only in async mode with internal clock.
// RULE_18: software sets clock selects before choosing the operating mode.
// RULE_19: 00 internal, pin out in sync; 01 internal pin out; 1x external.
// RULE_20: async output clock at bit rate; external input at sixteen times it.
// RULE_21: mode register bit 7: zero async, one clocked synchronous.
// RULE_22: each irq output is flag AND enable, so either clear removes it.
module scp_serial_port (
    // clock and reset
    input wire logic clock,
    input wire logic clock_en,
    input wire logic reset_n,
    input wire logic standby,
    input wire logic module_standby,
    // register port
    input wire scp_pkg::scp_bus_t bus,
    output logic [7:0] rdata,
    // serial pins
    output logic tx_pin,
    input wire logic rx_pin,
    input wire logic serial_clk_in,
    output logic serial_clk_out,
    output logic serial_clk_oe,
    // interrupt requests
    output logic tx_empty_irq,
    output logic rx_full_irq,
    output logic rx_error_irq,
    output logic tx_done_irq
);
    import scp_pkg::*;

    function automatic logic [11:0] tick_limit(input logic [1:0] sel);
        tick_limit = TICK_DIV << {sel, 1'b0};
    endfunction : tick_limit

    ////////////////////////////////////////////////////////////////////////
    // registers and state
    logic [7:0] serial_control_reg, serial_mode_reg, tx_holding_reg, rx_holding_reg;
    logic [7:0] flags, seen;
    logic tx_end_flag, addr_bit_flag, addr_bit_tx;
    logic rx_s1, rx_s2, ck_s1, ck_s2, ck_s3;
    logic [11:0] div_cnt;
    logic [3:0] phase;
    scp_state_t tx_state, rx_state;
    logic [3:0] tx_cnt, rx_cnt;
    logic [2:0] tx_bit, rx_bit;
    logic [7:0] tx_shift_reg, rx_shift_reg;
    logic tx_addr_val, rx_addr_got, rx_stop_ok, rx_done;

    // standby clears everything just like chip reset
    wire clear_all = !reset_n || standby || module_standby;
    wire sync_mode = serial_mode_reg[MOD_SYNC]; // [RULE_21]
    wire tx_on = serial_control_reg[CTL_TX_ON];
    wire rx_on = serial_control_reg[CTL_RX_ON];
    wire ext_clk = serial_control_reg[CTL_CLK_SRC]; // [RULE_16]
    wire addr_mode = !sync_mode && serial_mode_reg[MOD_ADDR_FRAME];
    wire wait_active = serial_control_reg[CTL_ADDR_WAIT] && addr_mode; // [RULE_10]

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    wire wr_ctrl = bus.wr && bus.addr == SCP_CTRL_ADDR;
    wire wr_mode = bus.wr && bus.addr == SCP_MODE_ADDR;
    wire wr_stat = bus.wr && bus.addr == SCP_STAT_ADDR;
    wire wr_txd = bus.wr && bus.addr == SCP_TXD_ADDR;
    wire rd_stat = bus.rd && bus.addr == SCP_STAT_ADDR;
    wire [7:0] status_view = {flags[7:3], tx_end_flag, addr_bit_flag, addr_bit_tx};
    wire [7:0] read_mux = (bus.addr == SCP_CTRL_ADDR) ? serial_control_reg :
                          (bus.addr == SCP_MODE_ADDR) ? serial_mode_reg :
                          (bus.addr == SCP_STAT_ADDR) ? status_view :
                          (bus.addr == SCP_TXD_ADDR) ? tx_holding_reg :
                          (bus.addr == SCP_RXD_ADDR) ? rx_holding_reg : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // tick generation and clock pin
    wire int_tick = div_cnt == tick_limit(serial_mode_reg[MOD_DIV_HI:MOD_DIV_LO]);
    wire ext_tick = ck_s2 && !ck_s3; // external pin runs at 16x bit rate [RULE_20]
    wire ck_fall = !ck_s2 && ck_s3;
    wire tick = ext_clk ? ext_tick : int_tick;
    // pin drives only with internal clock; out-select matters in async only [RULE_17] [RULE_19]
    wire next_clk_oe = !ext_clk && (sync_mode || serial_control_reg[CTL_CLK_OUT]);

    always_ff @(posedge clock) begin
        if (clear_all) begin
            {rx_s1, rx_s2} <= 2'h3;
            {ck_s1, ck_s2, ck_s3} <= 3'h0;
            div_cnt <= 12'h000;
            phase <= 4'h0;
            serial_clk_out <= 1'b0;
            serial_clk_oe <= 1'b0;
        end else if (clock_en) begin
            {rx_s1, rx_s2} <= {rx_pin, rx_s1};
            {ck_s1, ck_s2, ck_s3} <= {serial_clk_in, ck_s1, ck_s2};
            div_cnt <= int_tick ? 12'h000 : div_cnt + 12'h001;
            phase <= tick ? phase + 4'h1 : phase;
            serial_clk_out <= phase[3]; // one period per bit [RULE_20]
            serial_clk_oe <= next_clk_oe; // [RULE_16] [RULE_19]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter
    wire tx_load = tx_state == SCP_IDLE && tx_on && !flags[ST_TX_EMPTY]; // [RULE_07]
    wire tx_bit_end = tick && tx_cnt == TICK_LAST;
    wire tx_last = tx_state == SCP_STOP && tx_bit_end;

    always_ff @(posedge clock) begin
        if (clear_all) begin
            tx_state <= SCP_IDLE;
            tx_cnt <= 4'h0;
            tx_bit <= 3'h0;
            tx_shift_reg <= 8'h00;
            tx_addr_val <= 1'b0;
            tx_pin <= 1'b1;
        end else if (clock_en) begin
            if (!tx_on) begin
                tx_state <= SCP_IDLE; // [RULE_06]
                tx_pin <= 1'b1;
            end else if (tx_load) begin
                tx_state <= SCP_START;
                tx_shift_reg <= tx_holding_reg;
                tx_addr_val <= addr_bit_tx;
                tx_cnt <= 4'h0;
                tx_bit <= 3'h0;
                tx_pin <= 1'b0;
            end else if (tick) begin
                tx_cnt <= tx_cnt + 4'h1;
                if (tx_bit_end) begin
                    case (tx_state)
                        SCP_START: begin
                            tx_state <= SCP_DATA;
                            tx_pin <= tx_shift_reg[0];
                        end
                        SCP_DATA: begin
                            tx_bit <= tx_bit + 3'h1;
                            tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
                            if (tx_bit == BIT_LAST) begin
                                tx_state <= addr_mode ? SCP_ADDR : SCP_STOP;
                                tx_pin <= addr_mode ? tx_addr_val : 1'b1;
                            end else begin
                                tx_pin <= tx_shift_reg[1];
                            end
                        end
                        SCP_ADDR: begin
                            tx_state <= SCP_STOP;
                            tx_pin <= 1'b1;
                        end
                        SCP_STOP: tx_state <= SCP_IDLE;
                        default: tx_state <= SCP_IDLE;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver
    // async waits for a low line; sync mode starts on the clock pin edge [RULE_09]
    wire rx_start = rx_state == SCP_IDLE && rx_on && (sync_mode ? ck_fall : !rx_s2);
    wire rx_bit_end = tick && rx_cnt == TICK_LAST;

    always_ff @(posedge clock) begin
        if (clear_all) begin
            rx_state <= SCP_IDLE;
            rx_cnt <= 4'h0;
            rx_bit <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_addr_got <= 1'b0;
            rx_stop_ok <= 1'b0;
            rx_done <= 1'b0;
        end else if (clock_en) begin
            rx_done <= 1'b0;
            if (!rx_on) begin
                rx_state <= SCP_IDLE; // [RULE_08]
            end else if (rx_start) begin
                rx_state <= SCP_START;
                rx_cnt <= 4'h0;
                rx_bit <= 3'h0;
            end else if (tick) begin
                rx_cnt <= rx_cnt + 4'h1;
                case (rx_state)
                    SCP_START: if (rx_cnt == TICK_MID) begin
                        // re-check mid start bit so a glitch is not a frame
                        rx_state <= rx_s2 ? SCP_IDLE : SCP_DATA;
                        rx_cnt <= 4'h0;
                    end
                    SCP_DATA: if (rx_bit_end) begin
                        rx_shift_reg <= {rx_s2, rx_shift_reg[7:1]};
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == BIT_LAST) begin
                            rx_state <= addr_mode ? SCP_ADDR : SCP_STOP;
                        end
                        rx_addr_got <= 1'b0;
                    end
                    SCP_ADDR: if (rx_bit_end) begin
                        rx_addr_got <= rx_s2;
                        rx_state <= SCP_STOP;
                    end
                    SCP_STOP: if (rx_bit_end) begin
                        rx_stop_ok <= rx_s2;
                        rx_done <= 1'b1;
                        rx_state <= SCP_IDLE;
                    end
                    default: rx_state <= SCP_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags; a hardware set beats a software clear in the same cycle
    wire rx_addr_hit = rx_done && wait_active && rx_addr_got; // [RULE_11] [RULE_13]
    // waiting for an address drops plain characters silently [RULE_12]
    wire rx_accept = rx_done && rx_on && !(wait_active && !rx_addr_got);
    wire rx_store = rx_accept && !flags[ST_RX_FULL] && rx_stop_ok; // [RULE_04]
    wire [7:0] flag_set = {tx_load || !tx_on, rx_store, rx_accept && flags[ST_RX_FULL],
                           rx_accept && !rx_stop_ok, 1'b0, 3'h0}; // [RULE_02] [RULE_06]
    // a status-write clear needs a prior read of one; a data write clears the empty flag [RULE_03] [RULE_05]
    wire [7:0] flag_clr = {wr_txd, 7'h00} | ({8{wr_stat}} & ~bus.wdata & seen);

    genvar gi;
    generate
        for (gi = ST_PARITY; gi <= ST_TX_EMPTY; gi++) begin : g_flag
            always_ff @(posedge clock) begin
                if (clear_all) begin
                    flags[gi] <= SCP_STAT_RST[gi];
                    seen[gi] <= 1'b0;
                end else if (clock_en) begin
                    flags[gi] <= flag_set[gi] || (flags[gi] && !flag_clr[gi]);
                    seen[gi] <= flags[gi] && (seen[gi] || rd_stat) && !flag_clr[gi];
                end
            end
        end
    endgenerate
    assign flags[2:0] = 3'h0;
    assign seen[2:0] = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // control, mode, data registers and interrupt outputs
    // hardware clear of the wait bit wins over a software write of one
    wire [7:0] next_ctrl = (wr_ctrl ? bus.wdata : serial_control_reg)
                           & ~({7'h00, rx_addr_hit} << CTL_ADDR_WAIT); // [RULE_11]
    wire rx_irq_ok = serial_control_reg[CTL_RX_IE] && !wait_active; // [RULE_12]

    always_ff @(posedge clock) begin
        if (clear_all) begin
            serial_control_reg <= SCP_CTRL_RST; // [RULE_01]
            serial_mode_reg <= SCP_MODE_RST;
            tx_holding_reg <= SCP_TXD_RST;
            rx_holding_reg <= SCP_RXD_RST;
            tx_end_flag <= SCP_STAT_RST[ST_TX_END];
            addr_bit_flag <= SCP_STAT_RST[ST_ADDR_BIT];
            addr_bit_tx <= SCP_STAT_RST[ST_ADDR_BIT_TX];
            rdata <= 8'h00;
            {tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq} <= 4'h0;
        end else if (clock_en) begin
            serial_control_reg <= next_ctrl; // [RULE_01]
            serial_mode_reg <= wr_mode ? bus.wdata : serial_mode_reg;
            tx_holding_reg <= wr_txd ? bus.wdata : tx_holding_reg;
            rx_holding_reg <= rx_store ? rx_shift_reg : rx_holding_reg;
            // end flag set as the last bit leaves with nothing new queued [RULE_14]
            tx_end_flag <= (tx_last && flags[ST_TX_EMPTY]) || (tx_end_flag && !tx_load); // [RULE_15]
            addr_bit_flag <= (rx_accept && addr_mode) ? rx_addr_got : addr_bit_flag; // [RULE_13]
            addr_bit_tx <= wr_stat ? bus.wdata[ST_ADDR_BIT_TX] : addr_bit_tx;
            rdata <= bus.rd ? read_mux : 8'h00;
            tx_empty_irq <= flags[ST_TX_EMPTY] && serial_control_reg[CTL_TX_EMPTY_IE]; // [RULE_22]
            rx_full_irq <= flags[ST_RX_FULL] && rx_irq_ok; // [RULE_22]
            rx_error_irq <= |flags[ST_OVERRUN:ST_PARITY] && rx_irq_ok; // [RULE_22]
            tx_done_irq <= tx_end_flag && serial_control_reg[CTL_TX_DONE_IE]; // [RULE_22]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // standby clears state like reset, so checks skip that cycle
    wire run_chk = clock_en && !standby && !module_standby;

    sequence tx_end_seen_s;
        clock_en && tx_last && flags[ST_TX_EMPTY] && serial_control_reg[CTL_TX_DONE_IE];
    endsequence
    sequence tx_end_irq_s;
        clock_en ##1 clock_en && tx_done_irq;
    endsequence

    ctrl_clear_a: assert property ((standby || module_standby) |=> serial_control_reg == SCP_CTRL_RST) // [RULE_01]
        else $error("control register not cleared by standby");
    tx_irq_gate_a: assert property (run_chk |=> // [RULE_02]
        tx_empty_irq == $past(flags[ST_TX_EMPTY] && serial_control_reg[CTL_TX_EMPTY_IE]))
        else $error("tx empty irq does not follow flag and enable");
    tx_off_empty_a: assert property (clock_en && !tx_on |=> flags[ST_TX_EMPTY] && tx_state == SCP_IDLE) // [RULE_06]
        else $error("tx off but empty flag low");
    rx_off_keep_a: assert property (run_chk && !rx_on && !wr_stat |=> // [RULE_08]
        $stable(flags[ST_RX_FULL:ST_FRAMING]))
        else $error("receive flags changed while receiver off");
    wait_drop_a: assert property (run_chk && rx_done && wait_active && !rx_addr_got |=> // [RULE_12]
        $stable(rx_holding_reg) && !$rose(flags[ST_RX_FULL]))
        else $error("character stored during address wait");
    addr_hit_a: assert property (run_chk && rx_addr_hit |=> // [RULE_13]
        !serial_control_reg[CTL_ADDR_WAIT] && addr_bit_flag)
        else $error("address character did not end the wait");
    tx_done_irq_a: assert property (tx_end_seen_s |=> tx_end_irq_s) // [RULE_14]
        else $error("tx done irq missing after last bit");
    clk_pin_dir_a: assert property (clock_en && ext_clk |=> !serial_clk_oe) // [RULE_19]
        else $error("clock pin driven with external clock selected");
    rx_start_a: assert property (run_chk && rx_on && !sync_mode && rx_state == SCP_IDLE && !rx_s2 |=> // [RULE_09]
        rx_state == SCP_START)
        else $error("start bit not taken");

    // an enable cleared drops its request on the next edge
    tx_empty_off_a: assert property (run_chk && !serial_control_reg[CTL_TX_EMPTY_IE] |=> !tx_empty_irq) // [RULE_03]
        else $error("tx empty irq stands with enable clear");
    rx_irq_off_a: assert property (run_chk && !serial_control_reg[CTL_RX_IE] |=> // [RULE_05]
        !rx_full_irq && !rx_error_irq)
        else $error("rx irq stands with enable clear");
    tx_done_off_a: assert property (run_chk && !serial_control_reg[CTL_TX_DONE_IE] |=> !tx_done_irq) // [RULE_15]
        else $error("tx done irq stands with enable clear");
    rx_store_a: assert property (run_chk && rx_store |=> // [RULE_04]
        flags[ST_RX_FULL] && rx_holding_reg == $past(rx_shift_reg))
        else $error("received character not stored");
    tx_load_end_a: assert property (run_chk && tx_load |=> // [RULE_07]
        flags[ST_TX_EMPTY] && !tx_end_flag && tx_state == SCP_START)
        else $error("frame load did not start a frame");
    clk_out_sel_a: assert property (run_chk && !ext_clk && !sync_mode |=> // [RULE_17]
        serial_clk_oe == $past(serial_control_reg[CTL_CLK_OUT]))
        else $error("clock output select ignored in async internal mode");
    sync_pin_out_a: assert property (run_chk && !ext_clk && sync_mode |=> serial_clk_oe) // [RULE_19]
        else $error("clock pin not driven in sync internal mode");
endmodule : scp_serial_port

// >>> scp_remote_station.sv
// remote serial station model facing the serial port control block
`timescale 1ns/100ps
module scp_remote_station (
    // serial lines
    input wire logic tx_pin,
    output logic rx_pin,
    output logic serial_clk_in,
    // bench control
    input wire logic link_run
);
    // bit time; with the external clock one bit is sixteen 80 ns periods
    int bit_ns = 1280;
    logic [7:0] got_byte = 8'h00;
    int got_count = 0;
    initial rx_pin = 1'b1;
    initial serial_clk_in = 1'b0;
    ////////////////////////////////////////
    // link clock stands still low while link_run is low
    always begin
        if (link_run) begin
            #40 serial_clk_in = ~serial_clk_in;
        end else begin
            serial_clk_in = 1'b0;
            @(posedge link_run);
            #13;
        end
    end
    ////////////////////////////////////////
    // one async frame: start, 8 data lsb first, optional address bit, stop
    task automatic send_frame(input logic [7:0] d, input bit with_addr, input logic addr_bit);
        rx_pin = 1'b0;
        #(bit_ns);
        for (int i = 0; i < 8; i++) begin
            rx_pin = d[i];
            #(bit_ns);
        end
        if (with_addr) begin
            rx_pin = addr_bit;
            #(bit_ns);
        end
        // stop bit, then idle high as the line pull-up leaves it
        rx_pin = 1'b1;
        #(bit_ns);
    endtask : send_frame
    ////////////////////////////////////////
    // capture transmitted frames at mid-bit
    always begin
        @(negedge tx_pin);
        #(bit_ns / 2);
        for (int i = 0; i < 8; i++) begin
            #(bit_ns);
            got_byte[i] = tx_pin;
        end
        #(bit_ns);
        got_count++;
    end
endmodule : scp_remote_station

// >>> scp_serial_port_tb_top.sv
// self-checking bench of the serial port control block
`timescale 1ns/100ps
module scp_serial_port_tb_top;
    import scp_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic standby = 1'b0;
    logic module_standby = 1'b0;
    scp_bus_t bus = '0;
    logic [7:0] rdata;
    logic tx_pin, rx_pin, serial_clk_in, serial_clk_out, serial_clk_oe;
    logic tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq;
    logic link_run = 1'b0;
    logic [7:0] seen;
    logic [3:0] irqs;
    int bad_count = 0;
    int comparisons = 0;
    assign irqs = {tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq};
    always #5 clock = ~clock;
    ////////////////////////////////////////
    scp_serial_port dut_u (.clock(clock), .clock_en(1'b1), .reset_n(reset_n), .standby(standby),
        .module_standby(module_standby), .bus(bus), .rdata(rdata), .tx_pin(tx_pin), .rx_pin(rx_pin),
        .serial_clk_in(serial_clk_in), .serial_clk_out(serial_clk_out), .serial_clk_oe(serial_clk_oe),
        .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq),
        .tx_done_irq(tx_done_irq));
    scp_remote_station remote_u (.tx_pin(tx_pin), .rx_pin(rx_pin), .serial_clk_in(serial_clk_in),
        .link_run(link_run));
    ////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        bus <= '0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge clock);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        bus <= '0;
        #1 seen = rdata;
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    // bounded wait; a miss shows up in the compare that follows
    task automatic wait_irq(input int b);
        for (int i = 0; i < 40000 && irqs[b] !== 1'b1; i++) begin
            @(posedge clock);
        end
        #1;
    endtask : wait_irq
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #400000;
        bad_count++;
        print_verdict();
    end
    ////////////////////////////////////////
    initial begin
        logic [1:0] clk_tab [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2};
        logic [7:0] mode_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80};
        logic [7:0] oe_tab [7] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
        time t0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        rd(SCP_CTRL_ADDR);
        check("control reset", seen, 8'h00);
        wr(3'h5, 8'h3c);
        rd(3'h5);
        check("unmapped read", seen, 8'h00);
        for (int k = 0; k < 2; k++) begin
            wr(SCP_CTRL_ADDR, 8'hc3);
            rd(SCP_CTRL_ADDR);
            check("control write", seen, 8'hc3);
            check("tx empty level", {7'h00, tx_empty_irq}, 8'h01);
            @(posedge clock);
            standby <= (k == 0);
            module_standby <= (k == 1);
            @(posedge clock);
            standby <= 1'b0;
            module_standby <= 1'b0;
            rd(SCP_CTRL_ADDR);
            check("control standby", seen, 8'h00);
        end
        // stale data while disabled must not start a frame later
        wr(SCP_TXD_ADDR, 8'h33);
        rd(SCP_STAT_ADDR);
        check("empty held", {7'h00, seen[ST_TX_EMPTY]}, 8'h01);
        link_run <= 1'b1;
        wr(SCP_CTRL_ADDR, 8'ha6);
        wr(SCP_TXD_ADDR, 8'h5a);
        cyc(1);
        check("tx empty cleared", {7'h00, tx_empty_irq}, 8'h00);
        wait_irq(3);
        check("tx empty irq", {7'h00, tx_empty_irq}, 8'h01);
        check("tx done cleared", {7'h00, tx_done_irq}, 8'h00);
        wait_irq(0);
        check("tx done irq", {7'h00, tx_done_irq}, 8'h01);
        check("tx byte", remote_u.got_byte, 8'h5a);
        check("tx frames", 8'(remote_u.got_count), 8'h01);
        wr(SCP_CTRL_ADDR, 8'ha2);
        cyc(3);
        check("tx done off", {7'h00, tx_done_irq}, 8'h00);
        check("tx empty kept", {7'h00, tx_empty_irq}, 8'h01);
        wr(SCP_CTRL_ADDR, 8'h22);
        cyc(3);
        check("tx empty off", {7'h00, tx_empty_irq}, 8'h00);
        wr(SCP_CTRL_ADDR, 8'h00);
        link_run <= 1'b0;
        remote_u.bit_ns = (int'(TICK_DIV) + 1) * 160;
        wr(SCP_CTRL_ADDR, 8'h50);
        remote_u.send_frame(8'ha5, 1'b0, 1'b0);
        wait_irq(2);
        check("rx full irq", {7'h00, rx_full_irq}, 8'h01);
        rd(SCP_RXD_ADDR);
        check("rx byte", seen, 8'ha5);
        remote_u.send_frame(8'h3c, 1'b0, 1'b0);
        wait_irq(1);
        check("rx error irq", {7'h00, rx_error_irq}, 8'h01);
        wr(SCP_CTRL_ADDR, 8'h40);
        rd(SCP_STAT_ADDR);
        check("rx flags kept", seen & 8'h60, 8'h60);
        wr(SCP_CTRL_ADDR, 8'h00);
        cyc(3);
        check("rx irqs off", {6'h00, rx_full_irq, rx_error_irq}, 8'h00);
        wr(SCP_STAT_ADDR, 8'h00);
        wr(SCP_CTRL_ADDR, 8'h40);
        cyc(3);
        check("rx flags cleared", {6'h00, rx_full_irq, rx_error_irq}, 8'h00);
        wr(SCP_MODE_ADDR, 8'h04);
        wr(SCP_CTRL_ADDR, 8'h58);
        remote_u.send_frame(8'h11, 1'b1, 1'b0);
        cyc(50);
        rd(SCP_STAT_ADDR);
        check("wait no load", seen & 8'h70, 8'h00);
        check("wait no irq", {7'h00, rx_full_irq}, 8'h00);
        remote_u.send_frame(8'h22, 1'b1, 1'b1);
        wait_irq(2);
        check("addr char irq", {7'h00, rx_full_irq}, 8'h01);
        rd(SCP_CTRL_ADDR);
        check("wait bit cleared", seen, 8'h50);
        rd(SCP_STAT_ADDR);
        check("addr status", seen & 8'h42, 8'h42);
        rd(SCP_RXD_ADDR);
        check("addr char data", seen, 8'h22);
        // wait bit without addressed frames must not block reception
        wr(SCP_STAT_ADDR, 8'h00);
        wr(SCP_MODE_ADDR, 8'h00);
        wr(SCP_CTRL_ADDR, 8'h58);
        remote_u.send_frame(8'h6e, 1'b0, 1'b0);
        wait_irq(2);
        rd(SCP_RXD_ADDR);
        check("wait ignored", seen, 8'h6e);
        wr(SCP_CTRL_ADDR, 8'h00);
        for (int k = 0; k < 7; k++) begin
            wr(SCP_CTRL_ADDR, {6'h00, clk_tab[k]});
            wr(SCP_MODE_ADDR, mode_tab[k]);
            cyc(3);
            check("clock pin drive", {7'h00, serial_clk_oe}, oe_tab[k]);
        end
        // pin clock in async internal mode runs at the bit rate
        wr(SCP_CTRL_ADDR, 8'h01);
        wr(SCP_MODE_ADDR, 8'h00);
        @(posedge serial_clk_out);
        t0 = $time;
        @(posedge serial_clk_out);
        check("clock pin period", 8'(($time - t0) / ((int'(TICK_DIV) + 1) * 10)), 8'h10);
        print_verdict();
    end
endmodule : scp_serial_port_tb_top
